// ==== rtl/pkc_panel_key_command.v ====
// panel key command logic: menu editing, multifunction key, run and stop
// assumes raw key levels from pins, Avalon-MM slave on the same clock
//
// What this block does
// - enter at level 3 saves the value, returns to level 2, next one
// - program key at level 3 drops the edit, returns to level 2
// - level-3 value blinks only when it may be edited
// - fixed parameters never edit; run-locked ones only while stopped
// - an active user password blocks edits from the panel
// - key function select: 0 off,1 channel,2 direction,3 forward_jog,4 reverse_jog
// - key function 0: multifunction key does nothing
// - channel switch with panel source: channel stays the same
// - channel switch with terminal source: toggle terminal and panel
// - channel switch with comm source: toggle comm and panel
// - function 2 inverts frequency direction, panel channel only
// - function 3 commands forward jog, panel channel only
// - function 4 commands reverse jog, panel channel only
// - multifunction key works both stopped and running
// - run key starts acceleration, panel channel only; display shows running frequency
// - stop key decelerates the motor down to stop
// - command source select: 0 panel, 1 terminal, 2 communication
`include "pkc_consts.vh"

module pkc_panel_key_command #(
  parameter DEB_CYC  = `PKC_DEB_CYC,
  parameter NUM_PAR  = 16
) (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // raw panel keys, high while pressed
  input  wire        keyEnter,
  input  wire        keyProgram,
  input  wire        keyMulti,
  input  wire        keyRun,
  input  wire        keyStop,
  input  wire        keyUp,
  input  wire        keyDown,
  // drive state from run control
  input  wire        motorMoving,
  // avalon-mm slave
  input  wire [15:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  output reg  [1:0]  response,
  // commands to the drive
  output reg         runCmd,
  output reg         dirReverse,
  output reg         forwardJog,
  output reg         reverseJog,
  output reg         panelActive,
  output reg  [1:0]  activeChannel,
  output reg         displayRunFreq,
  output reg         valueBlink,
  output reg  [1:0]  menuLevel,
  output reg  [3:0]  paramIndex,
  output reg         saveStrobe,
  output reg  [15:0] savedValue
);

  // menu states, one-hot
  localparam [2:0] ST_L1 = 3'b001;
  localparam [2:0] ST_L2 = 3'b010;
  localparam [2:0] ST_L3 = 3'b100;

  reg  [2:0]  state;
  reg  [15:0] keyFunctionSelect;
  reg  [15:0] commandSourceSelect;
  reg  [2:0]  ctrlBits;
  reg  [15:0] editValue;
  reg  [NUM_PAR-1:0] fixedMask;
  reg  [NUM_PAR-1:0] runLockMask;
  reg         channelToggled;
  reg         ackPending;

  wire [6:0]  press;
  wire [6:0]  level;
  wire [6:0]  rawKeys;
  wire        editAllowed;
  wire        busWr;
  wire        busRd;

  assign rawKeys = {keyDown, keyUp, keyStop, keyRun, keyMulti, keyProgram,
                    keyEnter};

  // one debouncer per key
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : gKey
      pkc_key_debounce #(
        .DEB_CYC (DEB_CYC)
      ) uDeb (
        .clk      (clk),
        .rstn     (rstn),
        .keyRaw   (rawKeys[gi]),
        .keyLevel (level[gi]),
        .keyPress (press[gi])
      );
    end
  endgenerate

  // true when a word hits a given register address
  function hit;
    input [15:0] a;
    input [15:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  // edit permission combines lock sources
  assign editAllowed = !fixedMask[paramIndex]
                     && !(runLockMask[paramIndex] && motorMoving)
                     && !ctrlBits[`PKC_CTRL_PWD];

  // one wait state: waitrequest drops the cycle after a request arrives
  assign waitrequest = (read | write) & ~ackPending;
  assign busWr = write & ackPending;
  assign busRd = read & ackPending;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ackPending <= 1'b0;
    end else begin
      ackPending <= (read | write) & ~ackPending;
    end
  end

  // register writes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      keyFunctionSelect   <= `PKC_RST_KEYFN;
      commandSourceSelect <= `PKC_RST_CMDSRC;
      ctrlBits            <= 3'h0;
      fixedMask           <= {NUM_PAR{1'b0}};
      runLockMask         <= {NUM_PAR{1'b0}};
    end else if (busWr) begin
      if (hit(address, `PKC_ADDR_KEYFN)) begin
        keyFunctionSelect <= writedata[15:0];
      end else if (hit(address, `PKC_ADDR_CMDSRC)) begin
        commandSourceSelect <= writedata[15:0];
      end else if (hit(address, `PKC_ADDR_CTRL)) begin
        ctrlBits <= writedata[2:0];
      end else if (hit(address, `PKC_ADDR_LOCKS)) begin
        runLockMask <= writedata[NUM_PAR-1:0];
        fixedMask   <= writedata[NUM_PAR+15:16];
      end
    end
  end

  // read mux and response; unmapped reads return zero with slave error
  always @* begin
    readdata = 32'h00000000;
    response = 2'h0;
    if (busRd) begin
      if (hit(address, `PKC_ADDR_KEYFN)) begin
        readdata = {16'h0000, keyFunctionSelect};
      end else if (hit(address, `PKC_ADDR_CMDSRC)) begin
        readdata = {16'h0000, commandSourceSelect};
      end else if (hit(address, `PKC_ADDR_CTRL)) begin
        readdata = {29'h0, ctrlBits};
      end else if (hit(address, `PKC_ADDR_STATUS)) begin
        readdata = {23'h0, motorMoving, valueBlink, menuLevel, panelActive,
                    reverseJog, forwardJog, dirReverse, runCmd};
      end else if (hit(address, `PKC_ADDR_PARSEL)) begin
        readdata = {28'h0, paramIndex};
      end else if (hit(address, `PKC_ADDR_EDITVAL)) begin
        readdata = {16'h0000, editValue};
      end else if (hit(address, `PKC_ADDR_SAVEDVAL)) begin
        readdata = {16'h0000, savedValue};
      end else if (hit(address, `PKC_ADDR_LOCKS)) begin
        readdata = {fixedMask, runLockMask};
      end else begin
        response = 2'h2;
      end
    end else if (busWr) begin
      if (!(hit(address, `PKC_ADDR_KEYFN) || hit(address, `PKC_ADDR_CMDSRC)
          || hit(address, `PKC_ADDR_CTRL) || hit(address, `PKC_ADDR_LOCKS)))
      begin
        response = 2'h2;
      end
    end
  end

  // menu walk: level 1 group, level 2 parameter, level 3 value
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= ST_L1;
      paramIndex <= 4'h0;
      editValue  <= 16'h0000;
      savedValue <= 16'h0000;
      saveStrobe <= 1'b0;
    end else begin
      saveStrobe <= 1'b0;
      case (state)
        ST_L1: begin
          if (press[0]) begin
            state <= ST_L2;
          end
        end
        ST_L2: begin
          if (press[0]) begin
            state     <= ST_L3;
            editValue <= savedValue;
          end else if (press[1]) begin
            state <= ST_L1;
          end else if (press[5]) begin
            paramIndex <= paramIndex + 4'h1;
          end else if (press[6]) begin
            paramIndex <= paramIndex - 4'h1;
          end
        end
        ST_L3: begin
          if (press[0]) begin
            // store only what was allowed to change
            if (editAllowed) begin
              savedValue <= editValue;
              saveStrobe <= 1'b1;
            end
            state      <= ST_L2;
            paramIndex <= paramIndex + 4'h1;
          end else if (press[1]) begin
            state     <= ST_L2;
            editValue <= savedValue;
          end else if (press[5] && editAllowed) begin
            editValue <= editValue + 16'h0001;
          end else if (press[6] && editAllowed) begin
            editValue <= editValue - 16'h0001;
          end
        end
        default: begin
          state <= ST_L1;
        end
      endcase
    end
  end

  // menu level and blink indication
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      menuLevel  <= 2'h1;
      valueBlink <= 1'b0;
    end else begin
      menuLevel  <= (state == ST_L3) ? 2'h3 :
                    (state == ST_L2) ? 2'h2 : 2'h1;
      valueBlink <= (state == ST_L3) && editAllowed;
    end
  end

  // channel toggle flag; held clear while the source select is panel
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channelToggled <= 1'b0;
    end else if (commandSourceSelect[1:0] == `PKC_SRC_PANEL) begin
      channelToggled <= 1'b0;
    end else if (press[2] && keyFunctionSelect[2:0] == `PKC_KF_CHAN
                 && keyFunctionSelect[15:3] == 13'h0) begin
      channelToggled <= ~channelToggled;
    end
  end

  // active channel follows source select and toggle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      activeChannel <= `PKC_SRC_PANEL;
      panelActive   <= 1'b1;
    end else begin
      if (channelToggled || commandSourceSelect[1:0] == `PKC_SRC_PANEL
          || commandSourceSelect[1:0] == 2'h3) begin
        activeChannel <= `PKC_SRC_PANEL;
        panelActive   <= 1'b1;
      end else begin
        activeChannel <= commandSourceSelect[1:0];
        panelActive   <= 1'b0;
      end
    end
  end

  // run, stop, direction and jog; keys act in any run state
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      runCmd         <= 1'b0;
      dirReverse     <= 1'b0;
      forwardJog     <= 1'b0;
      reverseJog     <= 1'b0;
      displayRunFreq <= 1'b0;
    end else begin
      // stop takes priority over run in the same cycle
      if (press[4]) begin
        runCmd <= 1'b0;
      end else if (press[3] && panelActive) begin
        runCmd <= 1'b1;
      end
      displayRunFreq <= runCmd | motorMoving;
      if (press[2] && panelActive && keyFunctionSelect == 16'h0002) begin
        dirReverse <= ~dirReverse;
      end
      // jog holds while the key stays down; function 0 keeps both jog outputs low
      forwardJog <= level[2] && panelActive
                    && keyFunctionSelect == 16'h0003;
      reverseJog <= level[2] && panelActive
                    && keyFunctionSelect == 16'h0004;
    end
  end

endmodule

// ==== rtl/pkc_consts.vh ====
// constant definitions for the panel key command logic
// assumes inclusion by bare name from rtl and verification files
`ifndef PKC_CONSTS_VH
`define PKC_CONSTS_VH

// register byte addresses
`define PKC_ADDR_KEYFN      16'h0f00
`define PKC_ADDR_CMDSRC     16'h0103
`define PKC_ADDR_CTRL       16'h1000
`define PKC_ADDR_STATUS     16'h1004
`define PKC_ADDR_PARSEL     16'h1008
`define PKC_ADDR_EDITVAL    16'h100c
`define PKC_ADDR_SAVEDVAL   16'h1010
`define PKC_ADDR_LOCKS      16'h1014

// key function select codes
`define PKC_KF_NONE         3'h0
`define PKC_KF_CHAN         3'h1
`define PKC_KF_DIR          3'h2
`define PKC_KF_FORWARD_JOG         3'h3
`define PKC_KF_REVERSE_JOG         3'h4

// command source codes
`define PKC_SRC_PANEL       2'h0
`define PKC_SRC_TERM        2'h1
`define PKC_SRC_COMM        2'h2

// reset values
`define PKC_RST_KEYFN       16'h0000
`define PKC_RST_CMDSRC      16'h0000

// ctrl register bit positions
`define PKC_CTRL_RUNLOCK    0
`define PKC_CTRL_FIXED      1
`define PKC_CTRL_PWD        2

// status register bit positions
`define PKC_ST_RUN          0
`define PKC_ST_REV          1
`define PKC_ST_JOGF         2
`define PKC_ST_JOGR         3
`define PKC_ST_PANEL        4
`define PKC_ST_LVL_LO       5
`define PKC_ST_BLINK        7
`define PKC_ST_MOVING       8

// debounce time in microseconds and cycles at 10 MHz
`define PKC_DEB_US          5
`define PKC_CLK_MHZ         10
`define PKC_DEB_CYC         (`PKC_DEB_US * `PKC_CLK_MHZ)

`endif

// ==== rtl/pkc_key_debounce.v ====
// one key: three-stage synchroniser, debounce filter, press pulse
// assumes an asynchronous raw key level, high while pressed
module pkc_key_debounce #(
  parameter DEB_CYC = 50
) (
  // clock and reset
  input  wire clk,
  input  wire rstn,
  // raw key and filtered result
  input  wire keyRaw,
  output reg  keyLevel,
  output reg  keyPress
);

  reg        sync1;
  reg        sync2;
  reg        sync3;
  reg [15:0] cnt;

  // sync3 is compared against sync2 and keyLevel, never sync1
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= keyRaw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // level must hold steady DEB_CYC cycles before it is accepted
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt      <= 16'h0000;
      keyLevel <= 1'b0;
      keyPress <= 1'b0;
    end else begin
      keyPress <= 1'b0;
      if (sync2 != sync3 || sync3 == keyLevel) begin
        cnt <= 16'h0000;
      end else if (cnt == DEB_CYC[15:0] - 16'h0001) begin
        cnt      <= 16'h0000;
        keyLevel <= sync3;
        keyPress <= sync3;  // one pulse per press
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

endmodule

// ==== verification/pkc_panel_key_command_chk.sv ====
// checker: bus timing and command outputs of the panel key block
// assumes one clock domain and binding to the top module
`include "pkc_consts.vh"
module pkc_panel_key_command_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // bus and drive signals
  input wire logic [15:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  input wire logic        motorMoving,
  input wire logic        runCmd,
  input wire logic        forwardJog,
  input wire logic        reverseJog,
  input wire logic        panelActive,
  input wire logic        displayRunFreq,
  input wire logic        valueBlink,
  input wire logic [1:0]  menuLevel,
  input wire logic        saveStrobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // decoded map; anything else must answer with an error
  wire req = read | write;
  wire mapped = address == `PKC_ADDR_KEYFN || address == `PKC_ADDR_CMDSRC
    || address == `PKC_ADDR_CTRL || address == `PKC_ADDR_STATUS
    || address == `PKC_ADDR_PARSEL || address == `PKC_ADDR_EDITVAL
    || address == `PKC_ADDR_SAVEDVAL || address == `PKC_ADDR_LOCKS;
  // only the configuration registers take writes
  wire wmapped = address == `PKC_ADDR_KEYFN || address == `PKC_ADDR_CMDSRC
    || address == `PKC_ADDR_CTRL || address == `PKC_ADDR_LOCKS;
  wire okAddr = read ? mapped : wmapped;
  property p_firstWait; req && !$past(req) |-> waitrequest; endproperty
  a_firstWait: assert property (p_firstWait) else $error("no wait state");
  property p_oneWait; req && waitrequest |=> !waitrequest; endproperty
  a_oneWait: assert property (p_oneWait) else $error("wait too long");
  property p_unmapped;
    req && !waitrequest && !okAddr |-> response == 2'h2 && readdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad error reply");
  property p_mapped; req && !waitrequest && okAddr |-> response == 2'h0;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped not ok");
  property p_strobe; saveStrobe |=> !saveStrobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  property p_save; saveStrobe |-> ##[0:2] menuLevel == 2'h2; endproperty
  a_save: assert property (p_save) else $error("save not at level 2");
  property p_blink; valueBlink |-> menuLevel == 2'h3; endproperty
  a_blink: assert property (p_blink) else $error("blink off level 3");
  property p_jog; forwardJog |-> panelActive && !reverseJog; endproperty
  a_jog: assert property (p_jog) else $error("jog not from panel");
  property p_disp; 1 |=> displayRunFreq == $past(runCmd | motorMoving);
  endproperty
  a_disp: assert property (p_disp) else $error("display lag wrong");
endmodule
bind pkc_panel_key_command pkc_panel_key_command_chk
  pkc_panel_key_command_chk_inst (.clk, .rstn, .address, .read, .write,
  .readdata, .waitrequest, .response, .motorMoving, .runCmd, .forwardJog,
  .reverseJog, .panelActive, .displayRunFreq, .valueBlink, .menuLevel,
  .saveStrobe);

// ==== verification/pkc_operator.sv ====
// operator model: presses one panel key, holds it, then stays quiet
// assumes a one-cycle go with key index 0 enter .. 6 down
module pkc_operator (
  // clock
  input  wire logic       clk,
  // request from bench
  input  wire logic       go,
  input  wire logic [2:0] idx,
  // key levels and status
  output logic      [6:0] keys,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] cnt = 0;
  // quiet gap far beyond the filter so each press counts once
  always @(posedge clk) begin
    if (go) begin
      keys <= 7'h01 << idx;
      cnt  <= 7'h34;
      busy <= 1'b1;
    end else if (cnt != 0) begin
      cnt  <= cnt - 7'h01;
      busy <= cnt != 7'h01;
      if (cnt == 7'h20)
        keys <= 7'h00;
    end
  end
  initial begin
    keys = 0;
    busy = 0;
  end
endmodule

// ==== verification/tb_pkc_panel_key_command.sv ====
// bench: register bus, panel keys and drive outputs of the key block
// assumes a 10 MHz clock and a short filter for quick runs
`include "pkc_consts.vh"
module tb_pkc_panel_key_command;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, motorMoving = 0, read = 0, write = 0, go = 0;
  logic [15:0] address = 0;
  logic [31:0] writedata = 0, rd;
  logic [2:0] idx = 0;
  logic [1:0] rsp, midJog;
  logic [3:0] pi;
  wire [6:0] keys;
  wire [31:0] readdata;
  wire [1:0] response, activeChannel, menuLevel;
  wire [3:0] paramIndex;
  wire [15:0] savedValue;
  wire busy, waitrequest, runCmd, dirReverse, forwardJog, reverseJog;
  wire panelActive, displayRunFreq, valueBlink, saveStrobe;
  int n_fail = 0, samples_checked = 0;
  pkc_panel_key_command #(.DEB_CYC(4)) pkc_panel_key_command_inst (
    .clk, .rstn, .keyEnter(keys[0]), .keyProgram(keys[1]),
    .keyMulti(keys[2]), .keyRun(keys[3]), .keyStop(keys[4]),
    .keyUp(keys[5]), .keyDown(keys[6]), .motorMoving, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .response, .runCmd,
    .dirReverse, .forwardJog, .reverseJog, .panelActive, .activeChannel,
    .displayRunFreq, .valueBlink, .menuLevel, .paramIndex, .saveStrobe,
    .savedValue);
  pkc_operator pkc_operator_inst (.clk, .go, .idx, .keys, .busy);
  always #50 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    rd = readdata;
    rsp = response;
    read <= 0;
    write <= 0;
    // two edges so registered outputs reflect the write before checks
    repeat (2) @(posedge clk);
    if (k >= 20) begin
      n_fail++;
      finish_test();
    end
  endtask
  // one key press; jog outputs are sampled while the key is held
  task automatic press(input logic [2:0] k);
    int t;
    t = 0;
    idx <= k;
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (16) @(negedge clk);
    midJog = {forwardJog, reverseJog};
    while (busy && t < 200) begin
      @(negedge clk);
      t++;
    end
    if (t >= 200) begin
      n_fail++;
      finish_test();
    end
    @(posedge clk);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    chk(menuLevel, 1);
    chk(panelActive, 1);
    bus(0, `PKC_ADDR_KEYFN, 0); chk(rd, 0);
    bus(0, `PKC_ADDR_CMDSRC, 0); chk(rd, 0);
    bus(0, 16'h2000, 0); chk({30'h0, rsp}, 2'h2);
    chk(rd, 0);
    $display("test reset done");
    press(3); chk(runCmd, 1);
    chk(displayRunFreq, 1);
    bus(1, `PKC_ADDR_KEYFN, 0); press(2); chk(dirReverse, 0);
    bus(1, `PKC_ADDR_KEYFN, 2); press(2); chk(dirReverse, 1);
    bus(1, `PKC_ADDR_KEYFN, 1); press(2); chk(activeChannel, 0);
    press(4); chk(runCmd, 0);
    bus(1, `PKC_ADDR_KEYFN, 3); press(2); chk(midJog, 2'h2);
    bus(1, `PKC_ADDR_KEYFN, 4); press(2); chk(midJog, 2'h1);
    chk(reverseJog, 0);
    $display("test run and multifunction done");
    for (int s = 1; s < 3; s++) begin
      bus(1, `PKC_ADDR_KEYFN, 1);
      bus(1, `PKC_ADDR_CMDSRC, s); chk(activeChannel, s);
      press(2); chk({panelActive, activeChannel}, 4);
      press(2); chk({panelActive, activeChannel}, s);
      bus(1, `PKC_ADDR_KEYFN, 2); press(2); chk(dirReverse, 1);
      bus(1, `PKC_ADDR_KEYFN, 3); press(2); chk(midJog, 0);
      press(3); chk(runCmd, 0);
    end
    bus(1, `PKC_ADDR_CMDSRC, 0);
    $display("test channels done");
    press(0); press(0); chk(menuLevel, 3);
    chk(valueBlink, 1);
    press(5);
    pi = paramIndex;
    press(0); chk(savedValue, 16'h0001);
    chk({menuLevel, paramIndex}, {2'h2, pi + 4'h1});
    press(0); press(5);
    press(1); chk({menuLevel, paramIndex}, {2'h2, pi + 4'h1});
    chk(savedValue, 16'h0001);
    bus(1, `PKC_ADDR_CTRL, 4); press(0); chk(valueBlink, 0);
    press(5); press(0); chk(savedValue, 16'h0001);
    bus(1, `PKC_ADDR_CTRL, 0);
    bus(1, `PKC_ADDR_LOCKS, 32'h1 << paramIndex);
    motorMoving <= 1;
    press(0); chk(valueBlink, 0);
    motorMoving <= 0;
    repeat (3) @(posedge clk);
    chk(valueBlink, 1);
    press(1);
    bus(1, `PKC_ADDR_LOCKS, 32'h10000 << paramIndex);
    press(0); chk(valueBlink, 0);
    press(1);
    $display("test editing done");
    finish_test();
  end
endmodule
